/* hw/prx_pkg.sv */
// Constants for the proximity mode, emitter pulse and emitter current registers.
// Assumes one 10 MHz core clock and a host reaching the registers over the two-wire bus.
// Operation
// - After power-up the sensor sits in standby and measures nothing.
// - Standby measures nothing but every register stays readable and writable.
// - The serial bus logic works in standby and in active mode alike.
// - Mode bit 1 picks standby (0, default) or active periodic measurement (1).
// - Writing 1 to mode bit 0 restores all defaults and forces standby.
// - Bit 4 clear caps results at 11 bits; set passes all 16 bits.
// - Bit 3 set subtracts the crosstalk offset from each result.
// - Bit 2 enables far/near transition status; clear suppresses it.
// - Bit 7 set selects the fast persistence check within one period.
// - Pulse bits 3:2 give duty 25..100%, bits 1:0 width 8..64 us.
// - Current bits 4:0 step about 6.67 mA; codes 111xx give 186 mA.
package prx_pkg;
    // Bus address and register offsets
    localparam logic [6:0] PRX_SLAVE_ADDR = 7'h23;
    localparam logic [7:0] PRX_OFS_MODE = 8'h81;
    localparam logic [7:0] PRX_OFS_PULSE = 8'h82;
    localparam logic [7:0] PRX_OFS_CURRENT = 8'h83;
    // Values after reset
    localparam logic [7:0] PRX_RST_MODE = 8'h00;
    localparam logic [7:0] PRX_RST_PULSE = 8'h0e;
    localparam logic [7:0] PRX_RST_CURRENT = 8'h0f;
    // Implemented bits; reserved bits read as zero
    localparam logic [7:0] PRX_MASK_MODE = 8'h9e;
    localparam logic [7:0] PRX_MASK_PULSE = 8'h0f;
    localparam logic [7:0] PRX_MASK_CURRENT = 8'h1f;
    // Mode field positions
    localparam int PRX_BIT_SRST = 0;
    localparam int PRX_BIT_ACTIVE = 1;
    localparam int PRX_BIT_TRANS = 2;
    localparam int PRX_BIT_OS = 3;
    localparam int PRX_BIT_WIDE = 4;
    localparam int PRX_BIT_FAST = 7;
    // Result shaping
    localparam int PRX_RES_W = 16;
    localparam logic [15:0] PRX_NARROW_MAX = 16'h07ff;
    // Current codes 111xx all select the top step
    localparam logic [4:0] PRX_CUR_TOP_CODE = 5'h1c;
    // Emitter on-time: shortest width, doubled per width code
    localparam int PRX_CLK_NS = 100;
    localparam int PRX_WIDTH_MIN_NS = 8000;
    localparam logic [9:0] PRX_WIDTH_MIN_CYC =
        10'((PRX_WIDTH_MIN_NS + PRX_CLK_NS - 1) / PRX_CLK_NS);
    // Serial byte length
    localparam logic [3:0] PRX_BYTE_BITS = 4'h8;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
    } prx_bus_st_t;
endpackage

/* hw/prx_reg_if.sv */
// Interface between the serial front end and the register bank.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none
interface prx_reg_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] mode;
    logic [7:0] pulse;
    logic [7:0] current;
    logic srst;
    modport bus (output wr_en, addr, wdata, input rdata, mode, pulse, current, srst);
    modport bank (input wr_en, addr, wdata, output rdata, mode, pulse, current, srst);
endinterface
`default_nettype wire

/* hw/prx_reg_bank.sv */
// Register bank: mode control, emitter pulse shape and emitter drive current.
// Assumes one-cycle write strobes from the serial front end on the core clock.
`timescale 1ns/100ps
`default_nettype none
module prx_reg_bank (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Register access
    prx_reg_if.bank regs
);
    import prx_pkg::*;

    logic [7:0] mode_reg;
    logic [7:0] pulse_reg;
    logic [7:0] current_reg;
    logic srst_reg;
    logic soft_hit;
    logic mode_wr;

    assign mode_wr = regs.wr_en && (regs.addr == PRX_OFS_MODE);
    assign soft_hit = mode_wr && regs.wdata[PRX_BIT_SRST];

    // Mode register; the reset bit is self-clearing so it always reads 0
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= PRX_RST_MODE;
        end else if (ce) begin
            if (soft_hit) begin
                mode_reg <= PRX_RST_MODE;
            end else if (mode_wr) begin
                mode_reg <= regs.wdata & PRX_MASK_MODE;
            end
        end
    end

    // Emitter settings; a soft reset also returns them to defaults
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pulse_reg <= PRX_RST_PULSE;
            current_reg <= PRX_RST_CURRENT;
        end else if (ce) begin
            if (soft_hit) begin
                pulse_reg <= PRX_RST_PULSE;
                current_reg <= PRX_RST_CURRENT;
            end else if (regs.wr_en && regs.addr == PRX_OFS_PULSE) begin
                pulse_reg <= regs.wdata & PRX_MASK_PULSE;
            end else if (regs.wr_en && regs.addr == PRX_OFS_CURRENT) begin
                current_reg <= regs.wdata & PRX_MASK_CURRENT;
            end
        end
    end

    // One-cycle notice so the rest of the sensor reloads its calibration
    always_ff @(posedge core_clk) begin
        if (rst) begin
            srst_reg <= 1'b0;
        end else if (ce) begin
            srst_reg <= soft_hit;
        end
    end

    // Read mux; unmapped offsets read zero and are answered in any mode
    always_comb begin
        case (regs.addr)
            PRX_OFS_MODE: regs.rdata = mode_reg;
            PRX_OFS_PULSE: regs.rdata = pulse_reg;
            PRX_OFS_CURRENT: regs.rdata = current_reg;
            default: regs.rdata = 8'h00;
        endcase
    end

    assign regs.mode = mode_reg;
    assign regs.pulse = pulse_reg;
    assign regs.current = current_reg;
    assign regs.srst = srst_reg;

    chk_power_standby: assert property (@(posedge core_clk) disable iff (rst)
        $past(rst) |-> mode_reg == PRX_RST_MODE)
        else $error("mode not standby after reset");

    chk_soft_defaults: assert property (@(posedge core_clk) disable iff (rst)
        ce && soft_hit |=> mode_reg == PRX_RST_MODE && pulse_reg == PRX_RST_PULSE
            && current_reg == PRX_RST_CURRENT && srst_reg)
        else $error("soft reset did not restore defaults");

    chk_mode_select: assert property (@(posedge core_clk) disable iff (rst)
        ce && mode_wr && !regs.wdata[PRX_BIT_SRST]
            |=> mode_reg[PRX_BIT_ACTIVE] == $past(regs.wdata[PRX_BIT_ACTIVE])
            && !mode_reg[PRX_BIT_SRST] && !srst_reg)
        else $error("mode bit not taken from write");
endmodule
`default_nettype wire

/* hw/prx_sensor_ctrl.sv */
// Top of the proximity control block: serial slave, register bank, result shaping.
// Assumes bus pins are synchronous to core_clk and oversampled well above SCL.
`timescale 1ns/100ps
`default_nettype none
module prx_sensor_ctrl (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Two-wire bus pins; the data line is open drain
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Measurement results from the converter
    input wire logic [prx_pkg::PRX_RES_W-1:0] raw_result,
    input wire logic raw_valid,
    input wire logic [prx_pkg::PRX_RES_W-1:0] xtalk_offset,
    output logic [prx_pkg::PRX_RES_W-1:0] result_data,
    output logic result_valid,
    // Transition status: bit 1 far-to-near, bit 0 near-to-far
    input wire logic [1:0] trans_in,
    output logic [1:0] trans_status,
    // Settings for the measurement engine and emitter driver
    output logic measure_active,
    output logic fast_persist,
    output logic [1:0] emitter_duty_field,
    output logic [1:0] emitter_width_field,
    output logic [9:0] emitter_on_cycles,
    output logic [4:0] emitter_drive_code,
    output logic soft_reset_pulse
);
    import prx_pkg::*;

    prx_reg_if regs ();

    prx_reg_bank u_bank (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .regs(regs.bank)
    );

    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    prx_bus_st_t state_reg;
    prx_bus_st_t ret_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic ack_ok_reg;
    logic inc_reg;
    logic wr_reg;
    logic sda_oe_n_reg;
    logic sda_o_reg;

    // Previous pin levels for edge and condition detection
    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (ce) begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    assign scl_rise = scl_i && !scl_q;
    assign scl_fall = !scl_i && scl_q;
    assign start_det = scl_i && scl_q && sda_q && !sda_i;
    assign stop_det = scl_i && scl_q && !sda_q && sda_i;

    // Slave protocol; never gated by the measurement mode
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            ret_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            ack_ok_reg <= 1'b0;
            inc_reg <= 1'b0;
            wr_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else if (ce) begin
            wr_reg <= 1'b0;
            if (start_det) begin
                state_reg <= ST_ADDR;
                cnt_reg <= 4'h0;
                sda_oe_n_reg <= 1'b1;
            end else if (stop_det) begin
                state_reg <= ST_IDLE;
                sda_oe_n_reg <= 1'b1;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                        cnt_reg <= 4'h0;
                    end
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_i};
                            cnt_reg <= cnt_reg + 4'h1;
                        end else if (scl_fall && cnt_reg == PRX_BYTE_BITS) begin
                            cnt_reg <= 4'h0;
                            sda_oe_n_reg <= 1'b0;
                            state_reg <= ST_ACK;
                            inc_reg <= 1'b0;
                            if (state_reg == ST_ADDR) begin
                                // Foreign address: stay off the bus until the next start
                                if (shift_reg[7:1] != PRX_SLAVE_ADDR) begin
                                    state_reg <= ST_IDLE;
                                    sda_oe_n_reg <= 1'b1;
                                end
                                ret_reg <= shift_reg[0] ? ST_RDATA : ST_PTR;
                            end else if (state_reg == ST_PTR) begin
                                ptr_reg <= shift_reg;
                                ret_reg <= ST_WDATA;
                            end else begin
                                wr_reg <= 1'b1;
                                inc_reg <= 1'b1;
                                ret_reg <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            state_reg <= ret_reg;
                            if (ret_reg == ST_RDATA) begin
                                shift_reg <= regs.rdata;
                                sda_oe_n_reg <= regs.rdata[7];
                                cnt_reg <= 4'h1;
                                ptr_reg <= ptr_reg + 8'h01;
                            end else begin
                                sda_oe_n_reg <= 1'b1;
                                if (inc_reg) begin
                                    ptr_reg <= ptr_reg + 8'h01;
                                end
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (cnt_reg == PRX_BYTE_BITS) begin
                                sda_oe_n_reg <= 1'b1;
                                state_reg <= ST_RACK;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                sda_oe_n_reg <= shift_reg[6];
                                cnt_reg <= cnt_reg + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            ack_ok_reg <= !sda_i;
                        end else if (scl_fall) begin
                            if (ack_ok_reg) begin
                                shift_reg <= regs.rdata;
                                sda_oe_n_reg <= regs.rdata[7];
                                cnt_reg <= 4'h1;
                                ptr_reg <= ptr_reg + 8'h01;
                                state_reg <= ST_RDATA;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        sda_oe_n_reg <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Open drain: the data level is always low, only the enable moves
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sda_o_reg <= 1'b0;
        end else begin
            sda_o_reg <= 1'b0;
        end
    end

    assign regs.wr_en = wr_reg;
    assign regs.addr = ptr_reg;
    assign regs.wdata = shift_reg;
    assign sda_o = sda_o_reg;
    assign sda_oe_n = sda_oe_n_reg;

    // Settings registered once more so every output comes from a flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            measure_active <= 1'b0;
            fast_persist <= 1'b0;
            emitter_duty_field <= PRX_RST_PULSE[3:2];
            emitter_width_field <= PRX_RST_PULSE[1:0];
            emitter_on_cycles <= PRX_WIDTH_MIN_CYC << PRX_RST_PULSE[1:0];
            emitter_drive_code <= PRX_RST_CURRENT[4:0];
            soft_reset_pulse <= 1'b0;
        end else if (ce) begin
            measure_active <= regs.mode[PRX_BIT_ACTIVE];
            fast_persist <= regs.mode[PRX_BIT_FAST];
            emitter_duty_field <= regs.pulse[3:2];
            emitter_width_field <= regs.pulse[1:0];
            emitter_on_cycles <= PRX_WIDTH_MIN_CYC << regs.pulse[1:0];
            // The top step is shared by four codes, so collapse them
            emitter_drive_code <= (regs.current[4:2] == 3'h7) ? PRX_CUR_TOP_CODE
                : regs.current[4:0];
            soft_reset_pulse <= regs.srst;
        end
    end

    // Offset removal floors at zero rather than wrapping
    logic [PRX_RES_W-1:0] diff;
    assign diff = !regs.mode[PRX_BIT_OS] ? raw_result
        : (raw_result > xtalk_offset ? raw_result - xtalk_offset : '0);

    // Results pass only in active mode; standby drops them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_data <= '0;
            result_valid <= 1'b0;
        end else if (ce) begin
            result_valid <= raw_valid && regs.mode[PRX_BIT_ACTIVE];
            if (raw_valid && regs.mode[PRX_BIT_ACTIVE]) begin
                result_data <= regs.mode[PRX_BIT_WIDE] ? diff
                    : (diff > PRX_NARROW_MAX ? PRX_NARROW_MAX : diff);
            end
        end
    end

    // Transition status is blanked while reporting is off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trans_status <= 2'h0;
        end else if (ce) begin
            trans_status <= regs.mode[PRX_BIT_TRANS] ? trans_in : 2'h0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic take_res;
    assign take_res = ce && raw_valid && regs.mode[PRX_BIT_ACTIVE];

    sequence s_mode_wr;
        ce && regs.wr_en && regs.addr == PRX_OFS_MODE && !regs.wdata[PRX_BIT_SRST];
    endsequence
    sequence s_pulse_wr;
        ce && regs.wr_en && regs.addr == PRX_OFS_PULSE;
    endsequence

    chk_result_standby: assert property (
        result_valid |-> $past(regs.mode[PRX_BIT_ACTIVE]))
        else $error("result emitted in standby");
    chk_narrow_cap: assert property (
        take_res && !regs.mode[PRX_BIT_WIDE] |=> result_data <= PRX_NARROW_MAX)
        else $error("narrow result above 11-bit cap");
    chk_offset_sub: assert property (
        take_res && regs.mode[PRX_BIT_WIDE] && regs.mode[PRX_BIT_OS]
            && raw_result >= xtalk_offset
            |=> result_data == $past(raw_result) - $past(xtalk_offset))
        else $error("offset not subtracted");
    chk_no_offset: assert property (
        take_res && regs.mode[PRX_BIT_WIDE] && !regs.mode[PRX_BIT_OS]
            |=> result_data == $past(raw_result))
        else $error("result altered without offset mode");
    chk_trans_gate: assert property (
        ce && !regs.mode[PRX_BIT_TRANS] |=> trans_status == 2'h0)
        else $error("transition status not suppressed");
    chk_fast_persist: assert property (
        s_mode_wr ##1 ce |=> fast_persist == $past(regs.wdata[PRX_BIT_FAST], 2))
        else $error("persistence select not applied");
    chk_pulse_width: assert property (
        s_pulse_wr ##1 ce |=> emitter_on_cycles == PRX_WIDTH_MIN_CYC << $past(regs.wdata[1:0], 2)
            && emitter_duty_field == $past(regs.wdata[3:2], 2))
        else $error("emitter pulse settings wrong");
    chk_drive_top: assert property (
        ce && regs.current[4:2] == 3'h7 |=> emitter_drive_code == PRX_CUR_TOP_CODE)
        else $error("top current code not collapsed");
    chk_soft_standby: assert property (
        ce && regs.srst |=> !measure_active && soft_reset_pulse)
        else $error("soft reset left sensor active");
    chk_addr_ack: assert property (
        ce && state_reg == ST_ADDR && scl_fall && !start_det && !stop_det
            && cnt_reg == PRX_BYTE_BITS && shift_reg[7:1] == PRX_SLAVE_ADDR
            |=> !sda_oe_n && state_reg == ST_ACK)
        else $error("own address not acknowledged");
endmodule
`default_nettype wire

/* dv/prx_host_model.sv */
// Host controller model: drives the two-wire bus to reach the sensor registers.
// Assumes the bench resolves SDA with a pull-up and feeds the level back.
`timescale 1ns/100ps
`default_nettype none
module prx_host_model
    import prx_pkg::*;
(
    // Clock and bus
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl_o,
    output logic sda_rel
);
    logic ack_ok;
    logic in_frame;

    // Bus idles high; SCL stands still outside frames
    initial begin
        scl_o = 1'b1;
        sda_rel = 1'b1;
        ack_ok = 1'b1;
        in_frame = 1'b0;
    end

    // Every change lands just after an edge and holds for n cycles
    task automatic step(input logic s, input logic d, input int n);
        scl_o = s;
        sda_rel = d;
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // SCL falls first, so data never moves while the clock is high
    task automatic fall();
        step(1'b0, sda_rel, 1);
    endtask

    // One clock: drive d (1 = released), sample the wire mid-high
    task automatic xbit(input logic d, output logic q);
        fall();
        step(1'b0, d, 2);
        step(1'b1, d, 2);
        q = sda_line;
        step(1'b1, d, 2);
    endtask

    // Only a repeated start lowers SCL first; from idle SCL stays high
    task automatic start_c();
        if (in_frame) begin
            fall();
            step(1'b0, 1'b1, 2);
        end
        step(1'b1, 1'b1, 4);
        step(1'b1, 1'b0, 4);
        in_frame = 1'b1;
    endtask

    task automatic stop_c();
        fall();
        step(1'b0, 1'b0, 2);
        step(1'b1, 1'b0, 4);
        step(1'b1, 1'b1, 4);
        in_frame = 1'b0;
    endtask

    // Byte out, MSB first; a missing acknowledge is remembered
    task automatic wbyte(input logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xbit(b[i], q);
        end
        xbit(1'b1, q);
        if (q !== 1'b0) begin
            ack_ok = 1'b0;
        end
    endtask

    task automatic rbyte(input logic nack, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, b[i]);
        end
        xbit(nack, q);
    endtask

    task automatic write_reg(input logic [7:0] p, input logic [7:0] v);
        start_c();
        wbyte({PRX_SLAVE_ADDR, 1'b0});
        wbyte(p);
        wbyte(v);
        stop_c();
    endtask

    // Emitter settings always go out with their inverted companion, 0x13 above
    // The companion's reserved bits stay zero as well
    task automatic write_paired(input logic [7:0] p, input logic [7:0] v);
        logic [7:0] m;
        m = (p == PRX_OFS_PULSE) ? PRX_MASK_PULSE : PRX_MASK_CURRENT;
        write_reg(p, v);
        write_reg(p + 8'h13, ~v & m);
    endtask

    // Pointer write, repeated start, one byte read and refused
    task automatic read_reg(input logic [7:0] p, output logic [7:0] v);
        start_c();
        wbyte({PRX_SLAVE_ADDR, 1'b0});
        wbyte(p);
        start_c();
        wbyte({PRX_SLAVE_ADDR, 1'b1});
        rbyte(1'b1, v);
        stop_c();
    endtask
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the proximity control block.
// Assumes the host model in dv/ and the design files under hw/.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    import prx_pkg::*;
    logic core_clk, rst, scl, host_sda, sda_line, sda_o, sda_oe_n, raw_valid, result_valid;
    logic [15:0] raw_result, xtalk_offset, result_data;
    logic [1:0] trans_in, trans_status, duty, width;
    logic measure_active, fast_persist, soft_reset_pulse;
    logic [9:0] on_cycles;
    logic [4:0] drive;
    int num_errors = 0;
    int total_checks = 0;
    int srst_seen = 0;

    // Open-drain wire with pull-up: low if either side pulls
    assign sda_line = host_sda & sda_oe_n;

    prx_host_model host (.core_clk(core_clk), .sda_line(sda_line), .scl_o(scl),
        .sda_rel(host_sda));

    prx_sensor_ctrl dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .raw_result(raw_result),
        .raw_valid(raw_valid), .xtalk_offset(xtalk_offset), .result_data(result_data),
        .result_valid(result_valid), .trans_in(trans_in), .trans_status(trans_status),
        .measure_active(measure_active), .fast_persist(fast_persist),
        .emitter_duty_field(duty), .emitter_width_field(width),
        .emitter_on_cycles(on_cycles), .emitter_drive_code(drive),
        .soft_reset_pulse(soft_reset_pulse));

    // 100 ns clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Counts soft reset notices mid-cycle, where the flop output has settled
    always @(negedge core_clk) begin
        if (soft_reset_pulse === 1'b1) begin
            srst_seen++;
        end
    end

    task automatic tk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] p, output logic [7:0] v);
        host.read_reg(p, v);
    endtask

    // One converter result; the answer shows just after the edge that takes it
    task automatic pulse(input logic [15:0] raw, input logic [15:0] exp_d);
        raw_result = raw;
        raw_valid = 1'b1;
        tk(1);
        raw_valid = 1'b0;
        `CHK(result_valid, 1'b1)
        `CHK(result_data, exp_d)
        tk(1);
    endtask

    task automatic t_reset();
        logic [7:0] v;
        `CHK(measure_active, 1'b0)
        `CHK(sda_o, 1'b0)
        `CHK({duty, width, on_cycles, drive}, {4'b1110, 10'd320, 5'h0f})
        rd(PRX_OFS_MODE, v);
        `CHK(v, PRX_RST_MODE)
        rd(PRX_OFS_PULSE, v);
        `CHK(v, 8'h0e)
        rd(PRX_OFS_CURRENT, v);
        `CHK(v, 8'h0f)
    endtask

    // Standby drops results but the bus still reads and writes
    task automatic t_standby();
        logic [7:0] v;
        raw_result = 16'h0123;
        raw_valid = 1'b1;
        tk(1);
        raw_valid = 1'b0;
        `CHK(result_valid, 1'b0)
        host.write_paired(PRX_OFS_PULSE, 8'h05);
        rd(PRX_OFS_PULSE, v);
        `CHK(v, 8'h05)
        `CHK(measure_active, 1'b0)
    endtask

    task automatic t_result();
        logic [7:0] v;
        xtalk_offset = 16'h0034;
        host.write_reg(PRX_OFS_MODE, 8'h1a);
        `CHK(measure_active, 1'b1)
        pulse(16'h1234, 16'h1200);
        pulse(16'h0010, 16'h0000);
        host.write_reg(PRX_OFS_MODE, 8'h02);
        pulse(16'h1234, 16'h07ff);
        pulse(16'h0123, 16'h0123);
        trans_in = 2'b10;
        tk(2);
        `CHK(trans_status, 2'b00)
        `CHK(fast_persist, 1'b0)
        host.write_reg(PRX_OFS_MODE, 8'h96);
        `CHK(trans_status, 2'b10)
        `CHK(fast_persist, 1'b1)
        pulse(16'h1234, 16'h1234);
        rd(PRX_OFS_MODE, v);
        `CHK(v, 8'h96)
    endtask

    // Every duty/width code, then every current code; reserved bits stay 0
    task automatic t_emitter();
        logic [7:0] cv;
        for (int c = 0; c < 16; c++) begin
            cv = 8'(c);
            host.write_paired(PRX_OFS_PULSE, cv);
            `CHK({duty, width}, cv[3:0])
            `CHK(on_cycles, 10'd80 << cv[1:0])
        end
        for (int c = 0; c < 32; c++) begin
            cv = 8'(c);
            host.write_paired(PRX_OFS_CURRENT, cv);
            `CHK(drive, (cv[4:2] == 3'b111) ? 5'h1c : cv[4:0])
        end
    endtask

    task automatic t_soft();
        logic [7:0] v;
        host.write_reg(PRX_OFS_MODE, 8'h01);
        `CHK(measure_active, 1'b0)
        `CHK(on_cycles, 10'd320)
        `CHK(srst_seen, 1)
        rd(PRX_OFS_MODE, v);
        `CHK(v, 8'h00)
        rd(PRX_OFS_PULSE, v);
        `CHK(v, 8'h0e)
        rd(PRX_OFS_CURRENT, v);
        `CHK(v, 8'h0f)
        `CHK(host.ack_ok, 1'b1)
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence: 12 reset cycles, then the scenarios in turn
    initial begin
        rst = 1'b1;
        raw_result = 16'h0000;
        raw_valid = 1'b0;
        xtalk_offset = 16'h0000;
        trans_in = 2'b00;
        tk(12);
        rst = 1'b0;
        tk(2);
        t_reset();
        t_standby();
        t_result();
        t_emitter();
        t_soft();
        summarize();
    end

    // Whole run needs about 25k cycles; 5 ms leaves ample margin
    initial begin
        #5000000;
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
